// File: src/iasb_pkg.sv
// Shared constants and types for the I/O alarm and status word bank.
// Assumes a single 25 MHz core clock and an APB register bus.
package iasb_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing.
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned MS_PER_S = 1000;
    // Cycles per millisecond tick, rounded up.
    localparam int unsigned MS_TICK_CYC = (CLK_HZ + MS_PER_S - 1) / MS_PER_S;
    // Least control output on-time for a heater current update.
    localparam int unsigned HOLD_MIN_TIME_MS = 100;
    localparam logic [7:0] HOLD_MIN_TICKS = 8'(HOLD_MIN_TIME_MS);

    // Heater current is measured in units of 0.1 A; 110.0 A limit.
    localparam logic [15:0] OVERCURRENT_LIMIT_DA = 16'h044c;

    ////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_INPUT_COUNT_ERROR = 8'h05;
    localparam logic [7:0] IDX_HEATER_OVERCURRENT = 8'h06;
    localparam logic [7:0] IDX_HEATER_FAULT_ALARM = 8'h07;
    localparam logic [7:0] IDX_CURRENT_HOLD_NOTICE = 8'h09;
    localparam logic [7:0] IDX_CHANNEL_ERROR_SUMMARY = 8'h0b;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
    localparam logic [7:0] IDX_CURRENT_MONITOR_ONE = 8'h22;
    localparam logic [7:0] IDX_CURRENT_MONITOR_TWO = 8'h23;

    ////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned POS_COUNT_ERR = 0;
    localparam int unsigned POS_OVERCUR_ONE = 0;
    localparam int unsigned POS_OVERCUR_TWO = 1;
    localparam int unsigned POS_BURNOUT_ONE = 0;
    localparam int unsigned POS_SHORT_ONE = 1;
    localparam int unsigned POS_BURNOUT_TWO = 4;
    localparam int unsigned POS_SHORT_TWO = 5;
    localparam int unsigned POS_HOLD_ONE = 0;
    localparam int unsigned POS_HOLD_TWO = 4;
    localparam int unsigned POS_CHAN_ERR = 0;

    // Interrupt status and mask layout: one bit per status word.
    localparam int unsigned IRQ_COUNT_ERR = 0;
    localparam int unsigned IRQ_OVERCUR = 1;
    localparam int unsigned IRQ_FAULT_ALARM = 2;
    localparam int unsigned IRQ_HOLD = 3;
    localparam int unsigned IRQ_CHAN_ERR = 4;
    localparam logic [15:0] IRQ_USED_MASK = 16'h001f;

    // Reset values.
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RST_IRQ_MASK = 16'h0000;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // Alarm conditions arriving on pins from the measurement front end.
    typedef struct packed {
        logic [3:0] count_err;
        logic [1:0] heater_burnout;
        logic [1:0] relay_short_circuit;
        logic [3:0] chan_err;
    } iasb_pins_s;

    localparam int unsigned PINS_W = $bits(iasb_pins_s);

endpackage

// File: src/iasb_pin_sync.sv
// Three-stage pin synchroniser with an agreement filter.
// Assumes asynchronous inputs; output changes once stages two and three agree.
module iasb_pin_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // Pins and filtered levels.
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] level_o
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    logic [W-1:0] level_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Stage one feeds only stage two, so a metastable value goes nowhere else.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_comb begin
            level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level_r[i];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
        end else begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level_o = level_r;

endmodule

// File: src/iasb_top.sv
// Read-only alarm and status word bank of a modular temperature controller.
// Assumes an APB master on core_clk_i and alarm pins from another domain.
// Control outputs and heater current samples come from logic on this clock.
//
// What this block does
// - Count errors of inputs one to four set bits 0 to 3 of the input word.
// - Overcurrent bit 0 is set while current one exceeds 110.0 A, else clear.
// - Overcurrent bit 1 is set while current two exceeds 110.0 A, else clear.
// - Fault bit 0 is 1 while sensor one has a heater burnout alarm.
// - Fault bit 4 is 1 while sensor two has a heater burnout alarm.
// - Fault bit 1 is 1 while sensor one has a relay short-circuit alarm.
// - Fault bit 5 is 1 while sensor two has a relay short-circuit alarm.
// - On-time under 100 ms keeps the monitor value and sets hold bit 0 or 4.
// - Channel errors one to four set bits 0 to 3 of the channel error word.
// - Burnout and short alarms mean heater burnout and relay short circuit.
module iasb_top
    import iasb_pkg::*;
#(
    parameter int unsigned MS_TICK = iasb_pkg::MS_TICK_CYC
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Alarm pins.
    input wire iasb_pkg::iasb_pins_s alarm_pins_i,
    // Control outputs and heater current samples, same clock.
    input wire logic [1:0] control_out_i,
    input wire logic [1:0][15:0] heater_current_i,
    // Interrupt.
    output logic irq_o
);

    import iasb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Address decode, used by the read path, the write path and the error answer.
    function automatic logic reg_hit(input logic [11:0] addr);
        logic [7:0] idx;
        logic known;
        idx = addr[9:2];
        case (idx)
            IDX_INPUT_COUNT_ERROR,
            IDX_HEATER_OVERCURRENT,
            IDX_HEATER_FAULT_ALARM,
            IDX_CURRENT_HOLD_NOTICE,
            IDX_CHANNEL_ERROR_SUMMARY,
            IDX_IRQ_STATUS,
            IDX_IRQ_MASK,
            IDX_CURRENT_MONITOR_ONE,
            IDX_CURRENT_MONITOR_TWO: known = 1'b1;
            default: known = 1'b0;
        endcase
        // Byte lanes and the upper window are decoded as well, so an alias
        // there is refused rather than folded onto a word.
        reg_hit = known && (addr[1:0] == 2'b00) && (addr[11:10] == 2'b00);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus phases; a write lands only in the access cycle, with pready up.
    logic apb_setup;
    logic apb_access;

    assign apb_setup = psel_i && !penable_i;
    assign apb_access = psel_i && penable_i;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.
    // Alarm levels may glitch; two agreeing stages stop a one-cycle blip.
    iasb_pins_s pins;
    logic [PINS_W-1:0] pins_flat;

    iasb_pin_sync #(
        .W(PINS_W)
    ) u_pin_sync (
        .core_clk_i(core_clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(alarm_pins_i),
        .level_o(pins_flat)
    );

    assign pins = iasb_pins_s'(pins_flat);

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick divider.
    logic [15:0] div_r;
    logic [15:0] div_nxt;
    logic ms_tick;

    always_comb begin
        ms_tick = (div_r == 16'(MS_TICK - 1));
        div_nxt = ms_tick ? 16'h0000 : div_r + 16'h0001;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_r <= 16'h0000;
        end else begin
            div_r <= div_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // On-time measurement and heater current hold, one per current sensor.
    // The on-time is resolved to whole milliseconds; a pulse of 99 ticks
    // plus a fraction still counts as short, which errs towards holding.
    logic [1:0] ctrl_prev_r;
    logic [1:0] ctrl_prev_nxt;
    logic [1:0][7:0] on_ms_r;
    logic [1:0][7:0] on_ms_nxt;
    logic [1:0] hold_r;
    logic [1:0] hold_nxt;
    logic [1:0][15:0] monitor_r;
    logic [1:0][15:0] monitor_nxt;
    logic [1:0] ctrl_rise;
    logic [1:0] ctrl_fall;
    logic [1:0] on_short;

    for (genvar c = 0; c < 2; c++) begin : g_sensor
        always_comb begin
            ctrl_rise[c] = control_out_i[c] && !ctrl_prev_r[c];
            ctrl_fall[c] = !control_out_i[c] && ctrl_prev_r[c];
            on_short[c] = on_ms_r[c] < HOLD_MIN_TICKS;
            ctrl_prev_nxt[c] = control_out_i[c];
            on_ms_nxt[c] = on_ms_r[c];
            hold_nxt[c] = hold_r[c];
            monitor_nxt[c] = monitor_r[c];
            if (ctrl_rise[c]) begin
                on_ms_nxt[c] = 8'h00;
            end else if (control_out_i[c] && ms_tick && on_short[c]) begin
                on_ms_nxt[c] = on_ms_r[c] + 8'h01;
            end
            if (ctrl_fall[c]) begin
                if (on_short[c]) begin
                    hold_nxt[c] = 1'b1;
                end else begin
                    hold_nxt[c] = 1'b0;
                    monitor_nxt[c] = heater_current_i[c];
                end
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_prev_r <= 2'b00;
            on_ms_r <= '0;
            hold_r <= 2'b00;
            monitor_r <= '0;
        end else begin
            ctrl_prev_r <= ctrl_prev_nxt;
            on_ms_r <= on_ms_nxt;
            hold_r <= hold_nxt;
            monitor_r <= monitor_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Live status words; only the hold bits are registered and stay set until a long on-time clears them.
    logic [15:0] input_count_error;
    logic [15:0] heater_overcurrent_status;
    logic [15:0] heater_fault_alarm_status;
    logic [15:0] current_hold_notice;
    logic [15:0] channel_error_summary;

    always_comb begin
        input_count_error = RST_WORD;
        heater_overcurrent_status = RST_WORD;
        heater_fault_alarm_status = RST_WORD;
        current_hold_notice = RST_WORD;
        channel_error_summary = RST_WORD;
        input_count_error[POS_COUNT_ERR +: 4] = pins.count_err;
        heater_overcurrent_status[POS_OVERCUR_ONE] =
            heater_current_i[0] > OVERCURRENT_LIMIT_DA;
        heater_overcurrent_status[POS_OVERCUR_TWO] =
            heater_current_i[1] > OVERCURRENT_LIMIT_DA;
        heater_fault_alarm_status[POS_BURNOUT_ONE] =
            pins.heater_burnout[0];
        heater_fault_alarm_status[POS_BURNOUT_TWO] =
            pins.heater_burnout[1];
        heater_fault_alarm_status[POS_SHORT_ONE] =
            pins.relay_short_circuit[0];
        heater_fault_alarm_status[POS_SHORT_TWO] =
            pins.relay_short_circuit[1];
        current_hold_notice[POS_HOLD_ONE] = hold_r[0];
        current_hold_notice[POS_HOLD_TWO] = hold_r[1];
        channel_error_summary[POS_CHAN_ERR +: 4] = pins.chan_err;
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt events: any status bit rising since the previous cycle.
    logic [4:0][15:0] words;
    logic [4:0][15:0] words_prev_r;
    logic [4:0][15:0] words_prev_nxt;
    logic [15:0] irq_sts_r;
    logic [15:0] irq_sts_nxt;
    logic [15:0] irq_mask_r;
    logic [15:0] irq_mask_nxt;
    logic [15:0] irq_event;
    logic wr_access;
    logic [7:0] wr_idx;
    logic sts_clr;
    logic mask_wr;

    // One flag per word keeps the mask short; the word itself tells which bit.
    assign words[IRQ_COUNT_ERR] = input_count_error;
    assign words[IRQ_OVERCUR] = heater_overcurrent_status;
    assign words[IRQ_FAULT_ALARM] = heater_fault_alarm_status;
    assign words[IRQ_HOLD] = current_hold_notice;
    assign words[IRQ_CHAN_ERR] = channel_error_summary;

    always_comb begin
        irq_event = 16'h0000;
        for (int i = 0; i < 5; i++) begin
            irq_event[i] = |(words[i] & ~words_prev_r[i]);
        end
        words_prev_nxt = words;
        wr_access = apb_access && pwrite_i && reg_hit(paddr_i);
        wr_idx = paddr_i[9:2];
        sts_clr = wr_access && (wr_idx == IDX_IRQ_STATUS);
        mask_wr = wr_access && (wr_idx == IDX_IRQ_MASK);
        irq_sts_nxt = irq_sts_r;
        irq_mask_nxt = irq_mask_r;
        // Writes to the status words fall through here and change nothing.
        if (sts_clr) begin
            irq_sts_nxt = irq_sts_r & ~pwdata_i[15:0];
        end
        if (mask_wr) begin
            irq_mask_nxt = pwdata_i[15:0] & IRQ_USED_MASK;
        end
        // A new event in the clearing cycle is kept: set wins over clear.
        irq_sts_nxt = (irq_sts_nxt | irq_event) & IRQ_USED_MASK;
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            words_prev_r <= '0;
            irq_sts_r <= RST_WORD;
            irq_mask_r <= RST_IRQ_MASK;
        end else begin
            words_prev_r <= words_prev_nxt;
            irq_sts_r <= irq_sts_nxt;
            irq_mask_r <= irq_mask_nxt;
        end
    end

    // A level output: it drops only once software clears or masks the flag.
    assign irq_o = |(irq_sts_r & irq_mask_r);

    ////////////////////////////////////////////////////////////////////////
    // APB read path: data is captured in the setup cycle and held through
    // the access phase, which always completes without wait states.
    // Reads of unmapped space return zero alongside the error answer.
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [15:0] rd_word;
    logic [7:0] rd_idx;

    always_comb begin
        rd_idx = paddr_i[9:2];
        unique case (rd_idx)
            IDX_INPUT_COUNT_ERROR: rd_word = input_count_error;
            IDX_HEATER_OVERCURRENT: rd_word = heater_overcurrent_status;
            IDX_HEATER_FAULT_ALARM: rd_word = heater_fault_alarm_status;
            IDX_CURRENT_HOLD_NOTICE: rd_word = current_hold_notice;
            IDX_CHANNEL_ERROR_SUMMARY: rd_word = channel_error_summary;
            IDX_IRQ_STATUS: rd_word = irq_sts_r;
            IDX_IRQ_MASK: rd_word = irq_mask_r;
            IDX_CURRENT_MONITOR_ONE: rd_word = monitor_r[0];
            IDX_CURRENT_MONITOR_TWO: rd_word = monitor_r[1];
            default: rd_word = RST_WORD;
        endcase
        prdata_nxt = prdata_r;
        if (apb_setup) begin
            prdata_nxt = (reg_hit(paddr_i) && !pwrite_i) ?
                {16'h0000, rd_word} : RST_RDATA;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_r <= RST_RDATA;
        end else begin
            prdata_r <= prdata_nxt;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = apb_access;
    assign pslverr_o = apb_access && !reg_hit(paddr_i);

endmodule

// File: verif/iasb_monitor.sv
// Checker of the status bank's APB answers and status words.
// Assumes binding to iasb_top and APB answered with no wait states.
module iasb_monitor (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pslverr_o,
    // Pins, currents and interrupt.
    input wire iasb_pkg::iasb_pins_s alarm_pins_i,
    input wire logic [1:0][15:0] heater_current_i,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import iasb_pkg::*;
    ////////////////////////////////////////
    // Pin-driven words are only judged once pins sat still past the synchroniser.
    iasb_pins_s pins_r;
    iasb_pins_s pins_nxt;
    logic [2:0] calm_r;
    logic [2:0] calm_nxt;
    logic rd;
    assign rd = psel_i && penable_i && !pwrite_i;
    always_comb begin
        pins_nxt = alarm_pins_i;
        calm_nxt = 3'h0;
        if (alarm_pins_i == pins_r)
            calm_nxt = (calm_r == 3'h7) ? calm_r : calm_r + 3'h1;
    end
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pins_r <= '0;
            calm_r <= 3'h0;
        end else begin
            pins_r <= pins_nxt;
            calm_r <= calm_nxt;
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    a_count_word: assert property (
        rd && paddr_i == 12'h014 && calm_r > 3'h5
        |-> prdata_o == {28'h0, pins_r.count_err})
        else $error("input error word wrong");
    a_chan_word: assert property (
        rd && paddr_i == 12'h02c && calm_r > 3'h5
        |-> prdata_o == {28'h0, pins_r.chan_err})
        else $error("channel error word wrong");
    a_fault_word: assert property (
        rd && paddr_i == 12'h01c && calm_r > 3'h5
        |-> prdata_o == {26'h0, pins_r.relay_short_circuit[1],
        pins_r.heater_burnout[1], 2'h0, pins_r.relay_short_circuit[0],
        pins_r.heater_burnout[0]}) else $error("fault word wrong");
    a_over_one: assert property (
        rd && paddr_i == 12'h018 |-> prdata_o[0] ==
        ($past(heater_current_i[0]) > OVERCURRENT_LIMIT_DA))
        else $error("overcurrent one wrong");
    a_over_two: assert property (
        rd && paddr_i == 12'h018 |-> prdata_o[15:1] == {14'h0,
        ($past(heater_current_i[1]) > OVERCURRENT_LIMIT_DA)})
        else $error("overcurrent two wrong");
    a_upper_zero: assert property (
        rd |-> prdata_o[31:16] == 16'h0) else $error("upper half set");
    a_gap_err: assert property (
        psel_i && penable_i && paddr_i == 12'h010
        |-> pslverr_o && (pwrite_i || prdata_o == 32'h0))
        else $error("unmapped access not refused");
    a_word_ok: assert property (
        psel_i && penable_i && paddr_i == 12'h01c |-> !pslverr_o)
        else $error("status word refused");
    a_irq_masked: assert property (
        psel_i && penable_i && pwrite_i && paddr_i == 12'h084
        && pwdata_i[4:0] == 5'h00 |=> !irq_o)
        else $error("irq high with mask clear");
endmodule

bind iasb_top iasb_monitor i_mon (
    .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
    .alarm_pins_i(alarm_pins_i), .heater_current_i(heater_current_i),
    .irq_o(irq_o)
);

// File: verif/iasb_host.sv
// Host model reading the status bank over APB.
// Assumes one caller at a time; a wait longer than 16 cycles gives up.
module iasb_host (
    // Clock.
    input wire logic core_clk_i,
    // APB master.
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 12'h000;
        pwdata_o = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd,
        output logic err, output logic ok);
        ok = 1'b0;
        @(posedge core_clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge core_clk_i);
        penable_o <= 1'b1;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge core_clk_i);
            ok = (pready_i === 1'b1);
        end
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Stale write data is flipped so nothing leans on it.
        pwdata_o <= ~d;
    endtask
endmodule

// File: verif/io_alarm_status_bank_test.sv
// Self-checking bench for the alarm and status word bank.
// Assumes the host model and the bound checker sit beside the bank.
module io_alarm_status_bank_test;
    timeunit 1ns;
    timeprecision 1ns;
    import iasb_pkg::*;
    localparam int unsigned TICK = 4;
    localparam logic [11:0] WORDS [5] = '{12'h014, 12'h018, 12'h01c,
        12'h024, 12'h02c};
    localparam logic [15:0] LIM [3] = '{16'h044b, 16'h044c, 16'h044d};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel, pen, pwr, prdy, perr, irq, e;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, v;
    iasb_pins_s pins = '0;
    logic [1:0] ctl = 2'b00;
    logic [1:0][15:0] cur = '0;
    int fail_count = 0;
    int check_count = 0;
    always #20 clk = ~clk;
    iasb_top #(.MS_TICK(TICK)) i_dut (.core_clk_i(clk), .rst_b_i(rst_b),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
        .pslverr_o(perr), .alarm_pins_i(pins), .control_out_i(ctl),
        .heater_current_i(cur), .irq_o(irq));
    iasb_host i_host (.core_clk_i(clk), .psel_o(psel), .penable_o(pen),
        .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwd),
        .prdata_i(prd), .pready_i(prdy), .pslverr_i(perr));
    ////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d fails %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] s, logic [31:0] x);
        check_count++;
        if (s !== x) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic acc(logic w, logic [11:0] a, logic [31:0] d);
        logic ok;
        i_host.xfer(w, a, d, v, e, ok);
        if (!ok) begin
            fail_count++;
            wrap_up();
        end
    endtask
    task automatic rchk(string n, logic [11:0] a, logic [31:0] x);
        acc(1'b0, a, 32'h0);
        chk(n, v, x);
    endtask
    // A long on period samples the current; a short one holds it.
    task automatic pulse(logic [1:0] m, logic [31:0] c, int n);
        @(posedge clk);
        cur <= c;
        ctl <= m;
        wt(n * TICK);
        @(posedge clk);
        ctl <= 2'b00;
        wt(2);
    endtask
    task automatic hchk(logic [31:0] m1, logic [31:0] m2, logic [31:0] h);
        rchk("mon one", 12'h088, m1);
        rchk("mon two", 12'h08c, m2);
        rchk("hold", 12'h024, h);
    endtask
    ////////////////////////////////////////
    task automatic t_codes;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            pins.count_err <= 4'h1 << i;
            pins.chan_err <= 4'h8 >> i;
            wt(6);
            rchk("count", 12'h014, 32'h1 << i);
            rchk("chan", 12'h02c, 32'h8 >> i);
        end
        @(posedge clk);
        pins <= '0;
        wt(6);
        rchk("count off", 12'h014, 32'h0);
        rchk("chan off", 12'h02c, 32'h0);
    endtask
    task automatic t_fault;
        logic [1:0] b, s;
        for (int i = 0; i < 4; i++) begin
            b = 2'(i);
            s = 2'(3 - i);
            @(posedge clk);
            pins.heater_burnout <= b;
            pins.relay_short_circuit <= s;
            wt(6);
            rchk("fault", 12'h01c,
                {26'h0, s[1], b[1], 2'h0, s[0], b[0]});
        end
    endtask
    task automatic t_bus;
        acc(1'b1, 12'h01c, 32'h0);
        chk("ro err", e, 1'b0);
        rchk("ro word", 12'h01c, 32'h11);
        acc(1'b1, 12'h014, 32'hffff);
        rchk("ro count", 12'h014, 32'h0);
        acc(1'b0, 12'h010, 32'h0);
        chk("gap err", e, 1'b1);
        chk("gap data", v, 32'h0);
    endtask
    task automatic t_over;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            cur <= {LIM[2 - i], LIM[i]};
            rchk("over", 12'h018, {30'h0, i == 0, i == 2});
        end
    endtask
    task automatic t_hold;
        pulse(2'b11, 32'h0222_0111, 110);
        hchk(32'h0111, 32'h0222, 32'h0);
        pulse(2'b11, 32'h0444_0333, 90);
        hchk(32'h0111, 32'h0222, 32'h11);
        pulse(2'b10, 32'h0555_0333, 110);
        hchk(32'h0111, 32'h0555, 32'h01);
    endtask
    task automatic t_irq;
        rchk("irq stat", 12'h080, 32'h1f);
        chk("irq masked", irq, 1'b0);
        acc(1'b1, 12'h084, 32'h1f);
        wt(1);
        chk("irq on", irq, 1'b1);
        acc(1'b1, 12'h080, 32'h1f);
        wt(1);
        chk("irq clr", irq, 1'b0);
        rchk("stat clr", 12'h080, 32'h0);
        @(posedge clk);
        pins.count_err <= 4'h4;
        wt(6);
        chk("irq new", irq, 1'b1);
        rchk("stat new", 12'h080, 32'h1);
        acc(1'b1, 12'h084, 32'h0);
        wt(1);
        chk("irq mask", irq, 1'b0);
    endtask
    ////////////////////////////////////////
    initial begin
        wt(20);
        rst_b <= 1'b1;
        foreach (WORDS[i]) rchk("reset", WORDS[i], 32'h0);
        chk("irq reset", irq, 1'b0);
        t_codes();
        t_fault();
        t_bus();
        t_over();
        t_hold();
        t_irq();
        wrap_up();
    end
endmodule
